// ### inc/amc_pkg.sv
// Constants, encodings and types shared by the activity monitor register bank
package amc_pkg;

  // ---------------------------------------------------------------
  // Register selection
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    AMC_REG_NONE,
    AMC_REG_CFG,
    AMC_REG_GCFG,
    AMC_REG_CLR0,
    AMC_REG_CLR1,
    AMC_REG_SET0,
    AMC_REG_SET1,
    AMC_REG_CTRL,
    AMC_REG_AUX3,
    AMC_REG_AUX2
  } amc_reg_t;

  // ---------------------------------------------------------------
  // System register key: {op0, op1, CRn, CRm, op2}
  // ---------------------------------------------------------------
  function automatic logic [15:0] amc_key(input logic [1:0] op0,
                                          input logic [2:0] op1,
                                          input logic [3:0] crn,
                                          input logic [3:0] crm,
                                          input logic [2:0] op2);
    amc_key = {op0, op1, crn, crm, op2};
  endfunction

  localparam logic [15:0] AMC_SR_CFG =
    amc_key(2'h3, 3'h3, 4'hF, 4'h2, 3'h1);
  localparam logic [15:0] AMC_SR_GCFG =
    amc_key(2'h3, 3'h3, 4'hF, 4'h2, 3'h2);
  localparam logic [15:0] AMC_SR_CLR0 =
    amc_key(2'h3, 3'h3, 4'hF, 4'h2, 3'h4);
  localparam logic [15:0] AMC_SR_CLR1 =
    amc_key(2'h3, 3'h3, 4'hF, 4'h3, 3'h0);
  localparam logic [15:0] AMC_SR_SET0 =
    amc_key(2'h3, 3'h3, 4'hF, 4'h2, 3'h5);
  localparam logic [15:0] AMC_SR_SET1 =
    amc_key(2'h3, 3'h3, 4'hF, 4'h3, 3'h1);
  localparam logic [15:0] AMC_SR_CTRL =
    amc_key(2'h3, 3'h3, 4'hF, 4'h2, 3'h0);
  localparam logic [15:0] AMC_SR_AUX3 =
    amc_key(2'h3, 3'h6, 4'h1, 4'h0, 3'h1);
  localparam logic [15:0] AMC_SR_AUX2 =
    amc_key(2'h3, 3'h4, 4'h1, 4'h0, 3'h1);

  // ---------------------------------------------------------------
  // External debug byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] AMC_DBG_CFG = 12'hE00;
  localparam logic [11:0] AMC_DBG_GCFG = 12'hCE0;
  localparam logic [11:0] AMC_DBG_CLR0 = 12'hC20;
  localparam logic [11:0] AMC_DBG_CLR1 = 12'hC24;
  localparam logic [11:0] AMC_DBG_SET0 = 12'hC00;
  localparam logic [11:0] AMC_DBG_SET1 = 12'hC04;
  localparam logic [11:0] AMC_DBG_CTRL = 12'hE04;

  // ---------------------------------------------------------------
  // Field positions and constant field values
  // ---------------------------------------------------------------
  localparam int AMC_CFG_GROUPS_LSB = 28;
  localparam int AMC_CFG_HALT_BIT = 24;
  localparam int AMC_CFG_SIZE_LSB = 8;
  localparam int AMC_GCFG_AUX_LSB = 8;
  localparam int AMC_CTRL_HALT_BIT = 10;
  localparam int AMC_AUX_TRAP_BIT = 30;
  localparam logic [3:0] AMC_GROUPS_VAL = 4'h1;
  localparam logic AMC_HALT_SUPPORT = 1'b1;
  localparam logic [5:0] AMC_SIZE_VAL = 6'h3F;
  localparam logic [7:0] AMC_NCNT_VAL = 8'h06;
  localparam int AMC_AUX_MAX = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic AMC_RST_EN = 1'b0;
  localparam logic AMC_RST_HALT = 1'b0;
  localparam logic AMC_RST_TRAP = 1'b0;
  localparam logic [31:0] AMC_RST_DATA = 32'h0000_0000;

endpackage

// ### rtl/amc_trap_check.sv
// Trap decision for one system register access to the monitor registers
`timescale 1ns/1ps
module amc_trap_check
  import amc_pkg::*;
(
  input wire logic [1:0] el, // Exception level of the access
  input wire logic nonsecure, // Access is from the Non-secure state
  input wire logic monitor_reg, // Target is an activity monitor register
  input wire logic el3_trap, // Trap bit of el3_aux_control
  input wire logic el2_trap, // Trap bit of el2_aux_control
  output logic trap_el3, // Access is taken to EL3
  output logic trap_el2 // Access is taken to EL2
);

  // ---------------------------------------------------------------
  // Trap routing
  // ---------------------------------------------------------------
  logic hit_el3;
  logic hit_el2;

  always_comb begin
    hit_el3 = monitor_reg && el3_trap && (el != 2'h3);
    hit_el2 = monitor_reg && el2_trap && nonsecure &&
              (el < 2'h2);
    // The trap to EL2 is the lower target and is taken first
    trap_el2 = hit_el2;
    trap_el3 = hit_el3 && !hit_el2;
  end

endmodule

// ### rtl/amc_regs.sv
// Activity monitor configuration and count enable register bank
//
// Behaviour
// - Group field reads groups minus one, 0x1
// - Halt-on-debug support bit always reads one
// - Counter size field reads all ones
// - Counter count field reads constant 0x06
// - Auxiliary group count field reads three
// - Architected group count field reads four
// - Architected clear bits read enables, one disables
// - Auxiliary clear bits read enables, one disables
// - Unimplemented enable bits read zero, ignore writes
// - Configuration registers readable from debug, read-only
// - Enable clear registers debug-visible, writes ignored
// - EL3 trap bit traps lower-level accesses
// - EL2 trap bit traps Non-secure EL1/EL0
// - Trap control sits at bit 30
// - Former enable bits in aux control read zero
// - Set bits read enables, one enables
// - Halt-on-debug stops counters while core halted
`timescale 1ns/1ps
module amc_regs
  import amc_pkg::*;
#(
  parameter int ARCH_CNT = 4, // Architected counters
  parameter int AUX_CNT = 3 // Auxiliary counters, 1 to AMC_AUX_MAX
)(
  input wire logic clk, // Core clock
  input wire logic reset_n, // Warm reset, active low
  input wire logic sr_valid, // System register access request
  input wire logic sr_write, // 1 write, 0 read
  input wire logic [1:0] sr_op0, // Encoding op0
  input wire logic [2:0] sr_op1, // Encoding op1
  input wire logic [3:0] sr_crn, // Encoding CRn
  input wire logic [3:0] sr_crm, // Encoding CRm
  input wire logic [2:0] sr_op2, // Encoding op2
  input wire logic [31:0] sr_wdata, // Write data
  input wire logic [1:0] sr_el, // Exception level of the access
  input wire logic sr_nonsecure, // Access from Non-secure state
  output logic sr_done, // One-cycle answer strobe
  output logic [31:0] sr_rdata, // Read data, zero unless read ok
  output logic sr_trap_el3, // Access trapped to EL3
  output logic sr_trap_el2, // Access trapped to EL2
  output logic sr_undef, // Unmapped or not permitted
  input wire logic dbg_valid, // Debug access request
  input wire logic dbg_write, // Debug write, always ignored
  input wire logic [11:0] dbg_addr, // Debug byte offset
  output logic dbg_done, // One-cycle answer strobe
  output logic [31:0] dbg_rdata, // Debug read data
  output logic dbg_err, // Unmapped debug offset
  input wire logic core_halted, // Core is halted in debug state
  output logic [ARCH_CNT+AUX_CNT-1:0] counter_run // Counter may count
);

  localparam int NCNT = ARCH_CNT + AUX_CNT;

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic amc_reg_t sr_decode(input logic [15:0] key);
    amc_reg_t sel;
    sel = AMC_REG_NONE;
    if (key == AMC_SR_CFG) begin
      sel = AMC_REG_CFG;
    end else if (key == AMC_SR_GCFG) begin
      sel = AMC_REG_GCFG;
    end else if (key == AMC_SR_CLR0) begin
      sel = AMC_REG_CLR0;
    end else if (key == AMC_SR_CLR1) begin
      sel = AMC_REG_CLR1;
    end else if (key == AMC_SR_SET0) begin
      sel = AMC_REG_SET0;
    end else if (key == AMC_SR_SET1) begin
      sel = AMC_REG_SET1;
    end else if (key == AMC_SR_CTRL) begin
      sel = AMC_REG_CTRL;
    end else if (key == AMC_SR_AUX3) begin
      sel = AMC_REG_AUX3;
    end else if (key == AMC_SR_AUX2) begin
      sel = AMC_REG_AUX2;
    end
    return sel;
  endfunction

  // Only monitor registers are visible to the debugger
  function automatic amc_reg_t dbg_decode(input logic [11:0] addr);
    amc_reg_t sel;
    sel = AMC_REG_NONE;
    if (addr == AMC_DBG_CFG) begin
      sel = AMC_REG_CFG;
    end else if (addr == AMC_DBG_GCFG) begin
      sel = AMC_REG_GCFG;
    end else if (addr == AMC_DBG_CLR0) begin
      sel = AMC_REG_CLR0;
    end else if (addr == AMC_DBG_CLR1) begin
      sel = AMC_REG_CLR1;
    end else if (addr == AMC_DBG_SET0) begin
      sel = AMC_REG_SET0;
    end else if (addr == AMC_DBG_SET1) begin
      sel = AMC_REG_SET1;
    end else if (addr == AMC_DBG_CTRL) begin
      sel = AMC_REG_CTRL;
    end
    return sel;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [ARCH_CNT-1:0] arch_en;
  logic [AUX_CNT-1:0] aux_en;
  logic halt_on_debug;
  logic el3_trap_bit;
  logic el2_trap_bit;
  logic [ARCH_CNT-1:0] next_arch_en;
  logic [AUX_CNT-1:0] next_aux_en;
  logic next_halt_on_debug;
  logic next_el3_trap_bit;
  logic next_el2_trap_bit;

  // ---------------------------------------------------------------
  // Read view
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_value(input amc_reg_t sel,
      input logic [ARCH_CNT-1:0] a_en, input logic [AUX_CNT-1:0] x_en,
      input logic halt, input logic t3, input logic t2);
    logic [31:0] v;
    v = AMC_RST_DATA;
    unique case (sel)
      AMC_REG_NONE: begin
        v = AMC_RST_DATA;
      end
      AMC_REG_CFG: begin
        v[AMC_CFG_GROUPS_LSB +: 4] = AMC_GROUPS_VAL;
        v[AMC_CFG_HALT_BIT] = AMC_HALT_SUPPORT;
        v[AMC_CFG_SIZE_LSB +: 6] = AMC_SIZE_VAL;
        v[7:0] = AMC_NCNT_VAL;
      end
      AMC_REG_GCFG: begin
        v[AMC_GCFG_AUX_LSB +: 8] = 8'(AUX_CNT);
        v[7:0] = 8'(ARCH_CNT);
      end
      AMC_REG_CLR0, AMC_REG_SET0: begin
        // Upper bits stay zero
        v[ARCH_CNT-1:0] = a_en;
      end
      AMC_REG_CLR1, AMC_REG_SET1: begin
        v[AUX_CNT-1:0] = x_en;
      end
      AMC_REG_CTRL: begin
        v[AMC_CTRL_HALT_BIT] = halt;
      end
      AMC_REG_AUX3: begin
        // Every other bit, old enable bits included, reads zero
        v[AMC_AUX_TRAP_BIT] = t3;
      end
      AMC_REG_AUX2: begin
        v[AMC_AUX_TRAP_BIT] = t2;
      end
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // System register access qualification
  // ---------------------------------------------------------------
  amc_reg_t sr_sel;
  logic sr_monitor;
  logic sr_no_perm;
  logic trap3;
  logic trap2;
  logic sr_ok;

  always_comb begin
    sr_sel = sr_decode(amc_key(sr_op0, sr_op1, sr_crn, sr_crm, sr_op2));
    sr_monitor = (sr_sel != AMC_REG_NONE) &&
                 (sr_sel != AMC_REG_AUX3) && (sr_sel != AMC_REG_AUX2);
    // Aux control registers belong to their own level and above
    sr_no_perm = (sr_sel == AMC_REG_NONE) ||
                 ((sr_sel == AMC_REG_AUX3) && (sr_el != 2'h3)) ||
                 ((sr_sel == AMC_REG_AUX2) && (sr_el < 2'h2));
    sr_ok = sr_valid && !sr_no_perm && !trap3 && !trap2;
  end

  amc_trap_check u_trap (
    .el(sr_el),
    .nonsecure(sr_nonsecure),
    .monitor_reg(sr_monitor),
    .el3_trap(el3_trap_bit),
    .el2_trap(el2_trap_bit),
    .trap_el3(trap3),
    .trap_el2(trap2)
  );

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  always_comb begin
    next_arch_en = arch_en;
    next_aux_en = aux_en;
    next_halt_on_debug = halt_on_debug;
    next_el3_trap_bit = el3_trap_bit;
    next_el2_trap_bit = el2_trap_bit;
    // Debug writes never reach here
    if (sr_ok && sr_write) begin
      unique case (sr_sel)
        AMC_REG_CLR0: begin
          next_arch_en = arch_en & ~sr_wdata[ARCH_CNT-1:0];
        end
        AMC_REG_CLR1: begin
          next_aux_en = aux_en & ~sr_wdata[AUX_CNT-1:0];
        end
        AMC_REG_SET0: begin
          next_arch_en = arch_en | sr_wdata[ARCH_CNT-1:0];
        end
        AMC_REG_SET1: begin
          next_aux_en = aux_en | sr_wdata[AUX_CNT-1:0];
        end
        AMC_REG_CTRL: begin
          next_halt_on_debug = sr_wdata[AMC_CTRL_HALT_BIT];
        end
        AMC_REG_AUX3: begin
          next_el3_trap_bit = sr_wdata[AMC_AUX_TRAP_BIT];
        end
        AMC_REG_AUX2: begin
          next_el2_trap_bit = sr_wdata[AMC_AUX_TRAP_BIT];
        end
        AMC_REG_NONE, AMC_REG_CFG, AMC_REG_GCFG: begin
          // Identification registers ignore writes
          next_arch_en = arch_en;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arch_en <= {ARCH_CNT{AMC_RST_EN}};
      aux_en <= {AUX_CNT{AMC_RST_EN}};
      halt_on_debug <= AMC_RST_HALT;
      el3_trap_bit <= AMC_RST_TRAP;
      el2_trap_bit <= AMC_RST_TRAP;
    end else begin
      arch_en <= next_arch_en;
      aux_en <= next_aux_en;
      halt_on_debug <= next_halt_on_debug;
      el3_trap_bit <= next_el3_trap_bit;
      el2_trap_bit <= next_el2_trap_bit;
    end
  end

  // ---------------------------------------------------------------
  // Counter run enables
  // ---------------------------------------------------------------
  logic [NCNT-1:0] next_counter_run;

  always_comb begin
    next_counter_run = {aux_en, arch_en};
    if (halt_on_debug && core_halted) begin
      next_counter_run = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_run <= '0;
    end else begin
      counter_run <= next_counter_run;
    end
  end

  // ---------------------------------------------------------------
  // System register answer
  // ---------------------------------------------------------------
  logic next_sr_done;
  logic [31:0] next_sr_rdata;
  logic next_sr_trap_el3;
  logic next_sr_trap_el2;
  logic next_sr_undef;

  always_comb begin
    next_sr_done = sr_valid;
    next_sr_rdata = sr_rdata;
    next_sr_trap_el3 = sr_trap_el3;
    next_sr_trap_el2 = sr_trap_el2;
    next_sr_undef = sr_undef;
    if (sr_valid) begin
      // A refused or write access returns zero data
      next_sr_rdata = AMC_RST_DATA;
      if (sr_ok && !sr_write) begin
        next_sr_rdata = read_value(sr_sel, arch_en, aux_en,
                                   halt_on_debug, el3_trap_bit,
                                   el2_trap_bit);
      end
      next_sr_trap_el3 = !sr_no_perm && trap3;
      next_sr_trap_el2 = !sr_no_perm && trap2;
      next_sr_undef = sr_no_perm;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_done <= 1'b0;
      sr_rdata <= AMC_RST_DATA;
      sr_trap_el3 <= 1'b0;
      sr_trap_el2 <= 1'b0;
      sr_undef <= 1'b0;
    end else begin
      sr_done <= next_sr_done;
      sr_rdata <= next_sr_rdata;
      sr_trap_el3 <= next_sr_trap_el3;
      sr_trap_el2 <= next_sr_trap_el2;
      sr_undef <= next_sr_undef;
    end
  end

  // ---------------------------------------------------------------
  // Debug answer
  // ---------------------------------------------------------------
  amc_reg_t dbg_sel;
  logic next_dbg_done;
  logic [31:0] next_dbg_rdata;
  logic next_dbg_err;

  always_comb begin
    dbg_sel = dbg_decode(dbg_addr);
    next_dbg_done = dbg_valid;
    next_dbg_rdata = dbg_rdata;
    next_dbg_err = dbg_err;
    if (dbg_valid) begin
      // Writes complete normally but change nothing
      next_dbg_rdata = AMC_RST_DATA;
      if (!dbg_write) begin
        next_dbg_rdata = read_value(dbg_sel, arch_en, aux_en,
                                    halt_on_debug, el3_trap_bit,
                                    el2_trap_bit);
      end
      next_dbg_err = (dbg_sel == AMC_REG_NONE);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dbg_done <= 1'b0;
      dbg_rdata <= AMC_RST_DATA;
      dbg_err <= 1'b0;
    end else begin
      dbg_done <= next_dbg_done;
      dbg_rdata <= next_dbg_rdata;
      dbg_err <= next_dbg_err;
    end
  end

endmodule

// ### testbench/amc_regs_checker.sv
// Concurrent checks on the ports of the activity monitor register bank
`timescale 1ns/1ps
module amc_regs_checker
  import amc_pkg::*;
#(
  parameter int ARCH_CNT = 4, // Architected counters
  parameter int AUX_CNT = 3 // Auxiliary counters
)(
  input wire logic clk, // Core clock
  input wire logic reset_n, // Warm reset, active low
  input wire logic sr_valid, // Request
  input wire logic sr_write, // Write
  input wire logic [1:0] sr_op0, // op0
  input wire logic [2:0] sr_op1, // op1
  input wire logic [3:0] sr_crn, // CRn
  input wire logic [3:0] sr_crm, // CRm
  input wire logic [2:0] sr_op2, // op2
  input wire logic [31:0] sr_wdata, // Write data
  input wire logic [1:0] sr_el, // Level
  input wire logic sr_nonsecure, // Non-secure
  input wire logic sr_done, // Answer
  input wire logic [31:0] sr_rdata, // Read data
  input wire logic sr_trap_el3, // Trap to EL3
  input wire logic sr_trap_el2, // Trap to EL2
  input wire logic sr_undef, // Undefined
  input wire logic dbg_valid, // Debug request
  input wire logic dbg_write, // Debug write
  input wire logic [11:0] dbg_addr, // Debug offset
  input wire logic dbg_done, // Debug answer
  input wire logic [31:0] dbg_rdata, // Debug data
  input wire logic dbg_err, // Debug error
  input wire logic core_halted, // Halted
  input wire logic [ARCH_CNT+AUX_CNT-1:0] counter_run // Run enables
);
  logic [15:0] key;
  logic rd3;
  assign key = {sr_op0, sr_op1, sr_crn, sr_crm, sr_op2};
  // EL3 reads are never trapped, so their data is always the register
  assign rd3 = sr_valid && !sr_write && sr_el == 2'h3;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  cfg_read_a: assert property (
    rd3 && key == AMC_SR_CFG |=> sr_done && sr_rdata == 32'h11003F06)
    else $error("configuration read value wrong");
  group_read_a: assert property (
    rd3 && key == AMC_SR_GCFG |=> sr_rdata == 32'h00000304)
    else $error("group configuration read value wrong");
  clr0_high_a: assert property (
    rd3 && key == AMC_SR_CLR0 |=> sr_rdata[31:4] == 28'h0)
    else $error("architected clear upper bits not zero");
  clr1_high_a: assert property (
    rd3 && key == AMC_SR_CLR1 |=> sr_rdata[31:3] == 29'h0)
    else $error("auxiliary clear upper bits not zero");
  dbg_cfg_a: assert property (
    dbg_valid && !dbg_write && dbg_addr == AMC_DBG_CFG
    |=> dbg_done && !dbg_err && dbg_rdata == 32'h11003F06)
    else $error("debug configuration read wrong");
  dbg_write_a: assert property (
    dbg_valid && dbg_write |=> dbg_done && dbg_rdata == 32'h0)
    else $error("debug write returned data");
  el3_free_a: assert property (
    sr_valid && sr_el == 2'h3 |=> !sr_trap_el3 && !sr_trap_el2)
    else $error("EL3 access trapped");
  secure_el2_a: assert property (
    sr_valid && !sr_nonsecure |=> !sr_trap_el2)
    else $error("secure access trapped to EL2");
  clear_stops_a: assert property (
    sr_valid && sr_write && key == AMC_SR_CLR0 && sr_el == 2'h3
    ##1 !(sr_valid && sr_write)
    |=> (counter_run[3:0] & $past(sr_wdata[3:0], 2)) == 4'h0)
    else $error("cleared counter still runs");

  aux_perm_a: assert property (
    sr_valid && key == AMC_SR_AUX3 && sr_el != 2'h3
    |=> sr_undef && !sr_trap_el3 && !sr_trap_el2 && sr_rdata == 32'h0)
    else $error("lower level reached EL3 aux control");

  cover property (sr_valid ##1 sr_trap_el3);
  cover property (sr_valid ##1 sr_trap_el2);
  cover property (dbg_valid ##1 dbg_err);
endmodule

bind amc_regs amc_regs_checker #(.ARCH_CNT(ARCH_CNT), .AUX_CNT(AUX_CNT))
  u_amc_regs_checker (.*);

// ### testbench/tb.sv
// Self-checking testbench for the activity monitor register bank
`timescale 1ns/1ps
module tb;
  import amc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sr_valid = 1'b0;
  logic sr_write = 1'b0;
  logic [15:0] sr_key = 16'h0000;
  logic [31:0] sr_wdata = 32'h0;
  logic [1:0] sr_el = 2'h0;
  logic sr_nonsecure = 1'b0;
  logic dbg_valid = 1'b0;
  logic dbg_write = 1'b0;
  logic [11:0] dbg_addr = 12'h000;
  logic core_halted = 1'b0;
  logic sr_done, sr_trap_el3, sr_trap_el2, sr_undef;
  logic dbg_done, dbg_err;
  logic [31:0] sr_rdata, dbg_rdata;
  logic [6:0] counter_run;
  int errors = 0;
  int checks_done = 0;

  always #50 clk = ~clk;

  amc_regs u_amc_regs (.clk(clk), .reset_n(reset_n), .sr_valid(sr_valid),
    .sr_write(sr_write), .sr_op0(sr_key[15:14]), .sr_op1(sr_key[13:11]),
    .sr_crn(sr_key[10:7]), .sr_crm(sr_key[6:3]), .sr_op2(sr_key[2:0]),
    .sr_wdata(sr_wdata), .sr_el(sr_el), .sr_nonsecure(sr_nonsecure),
    .sr_done(sr_done), .sr_rdata(sr_rdata), .sr_trap_el3(sr_trap_el3),
    .sr_trap_el2(sr_trap_el2), .sr_undef(sr_undef), .dbg_valid(dbg_valid),
    .dbg_write(dbg_write), .dbg_addr(dbg_addr), .dbg_done(dbg_done),
    .dbg_rdata(dbg_rdata), .dbg_err(dbg_err), .core_halted(core_halted),
    .counter_run(counter_run));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One access; the answer stands one cycle later, sampled mid-cycle
  task automatic sr(input logic wr, input logic [15:0] key,
                    input logic [31:0] wd, input logic [1:0] el,
                    input logic ns);
    @(negedge clk);
    sr_valid = 1'b1;
    sr_write = wr;
    sr_key = key;
    sr_wdata = wd;
    sr_el = el;
    sr_nonsecure = ns;
    @(negedge clk);
    sr_valid = 1'b0;
    check({31'h0, sr_done}, 32'h1);
  endtask

  task automatic rd(input logic [15:0] key, input logic [31:0] exp);
    sr(1'b0, key, 32'h0, 2'h3, 1'b0);
    check(sr_rdata, exp);
  endtask

  task automatic dbg(input logic wr, input logic [11:0] a,
                     input logic [31:0] exp, input logic err);
    @(negedge clk);
    dbg_valid = 1'b1;
    dbg_write = wr;
    dbg_addr = a;
    @(negedge clk);
    dbg_valid = 1'b0;
    check({30'h0, dbg_done, dbg_err}, {30'h0, 1'b1, err});
    check(dbg_rdata, exp);
  endtask

  task automatic t_ident();
    logic [15:0] k [6] = '{AMC_SR_CFG, AMC_SR_GCFG, AMC_SR_CLR0,
                           AMC_SR_CLR1, AMC_SR_SET0, AMC_SR_SET1};
    logic [11:0] a [6] = '{12'hE00, 12'hCE0, 12'hC20, 12'hC24, 12'hC00,
                           12'hC04};
    logic [31:0] e [6] = '{32'h11003F06, 32'h00000304, 32'h0, 32'h0,
                           32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(k[i], e[i]);
      dbg(1'b0, a[i], e[i], 1'b0);
    end
    check({25'h0, counter_run}, 32'h0);
  endtask

  task automatic t_enable();
    sr(1'b1, AMC_SR_SET0, 32'hFFFFFFFF, 2'h0, 1'b1);
    rd(AMC_SR_CLR0, 32'hF);
    sr(1'b1, AMC_SR_CLR0, 32'hFFFFFFF5, 2'h3, 1'b0);
    sr(1'b1, AMC_SR_CLR0, 32'h0, 2'h3, 1'b0);
    rd(AMC_SR_SET0, 32'hA);
    sr(1'b1, AMC_SR_SET1, 32'hFFFFFFFF, 2'h3, 1'b0);
    rd(AMC_SR_CLR1, 32'h7);
    sr(1'b1, AMC_SR_CLR1, 32'hFFFFFFFA, 2'h3, 1'b0);
    rd(AMC_SR_SET1, 32'h5);
    dbg(1'b1, AMC_DBG_CLR0, 32'h0, 1'b0);
    dbg(1'b1, AMC_DBG_SET1, 32'h0, 1'b0);
    dbg(1'b0, AMC_DBG_CLR0, 32'hA, 1'b0);
    dbg(1'b0, AMC_DBG_CLR1, 32'h5, 1'b0);
    check({25'h0, counter_run}, 32'h5A);
  endtask

  task automatic t_halt();
    sr(1'b1, AMC_SR_CTRL, 32'hFFFFFFFF, 2'h0, 1'b0);
    rd(AMC_SR_CTRL, 32'h400);
    dbg(1'b0, AMC_DBG_CTRL, 32'h400, 1'b0);
    core_halted = 1'b1;
    repeat (3) @(negedge clk);
    check({25'h0, counter_run}, 32'h0);
    core_halted = 1'b0;
    repeat (3) @(negedge clk);
    check({25'h0, counter_run}, 32'h5A);
    sr(1'b1, AMC_SR_CTRL, 32'h0, 2'h3, 1'b0);
    core_halted = 1'b1;
    repeat (3) @(negedge clk);
    check({25'h0, counter_run}, 32'h5A);
    core_halted = 1'b0;
  endtask

  task automatic t_trap();
    sr(1'b1, AMC_SR_AUX3, 32'hFFFFFFFF, 2'h3, 1'b0);
    rd(AMC_SR_AUX3, 32'h40000000);
    sr(1'b0, AMC_SR_CFG, 32'h0, 2'h1, 1'b0);
    check({30'h0, sr_trap_el3, sr_trap_el2}, 32'h2);
    check(sr_rdata, 32'h0);
    sr(1'b1, AMC_SR_SET0, 32'hF, 2'h2, 1'b1);
    check({30'h0, sr_trap_el3, sr_trap_el2}, 32'h2);
    sr(1'b1, AMC_SR_AUX3, 32'h0, 2'h3, 1'b0);
    rd(AMC_SR_CLR0, 32'hA);
    sr(1'b1, AMC_SR_AUX2, 32'h40000000, 2'h2, 1'b1);
    sr(1'b0, AMC_SR_AUX2, 32'h0, 2'h2, 1'b1);
    check(sr_rdata, 32'h40000000);
    sr(1'b0, AMC_SR_GCFG, 32'h0, 2'h0, 1'b1);
    check({30'h0, sr_trap_el3, sr_trap_el2}, 32'h1);
    sr(1'b0, AMC_SR_GCFG, 32'h0, 2'h1, 1'b0);
    check(sr_rdata, 32'h00000304);
    sr(1'b0, AMC_SR_GCFG, 32'h0, 2'h2, 1'b1);
    check({30'h0, sr_trap_el3, sr_trap_el2}, 32'h0);
    sr(1'b1, AMC_SR_AUX2, 32'h0, 2'h2, 1'b1);
  endtask

  task automatic t_unmapped();
    sr(1'b0, amc_key(2'h3, 3'h3, 4'hF, 4'h2, 3'h3), 32'h0, 2'h3, 1'b0);
    check({31'h0, sr_undef}, 32'h1);
    check(sr_rdata, 32'h0);
    dbg(1'b0, 12'h000, 32'h0, 1'b1);
    // A refused write must not arm the EL3 trap
    sr(1'b1, AMC_SR_AUX3, 32'hFFFFFFFF, 2'h2, 1'b0);
    check({31'h0, sr_undef}, 32'h1);
    sr(1'b0, AMC_SR_CFG, 32'h0, 2'h1, 1'b0);
    check({30'h0, sr_trap_el3, sr_trap_el2}, 32'h0);
    check(sr_rdata, 32'h11003F06);
  endtask

  // Watchdog: a hung sequence still ends in the closing report
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    t_ident();
    t_enable();
    t_halt();
    t_trap();
    t_unmapped();
    end_sim();
  end
endmodule
